/* File: rpnsc_alu_model.sv */
// Purpose: Behavioural datapath standing beside the operand stack
// Assumes: Result is combinational from the command and X, Y
// Notes: Single-operand results are half of |X|, so fractions appear
`timescale 1ns/1ps
module rpnsc_alu_model
  import rpnsc_pkg::*;
(
  input wire rpnsc_cmd_t cmd_i,
  input wire logic [31:0] x_i,
  input wire logic [31:0] y_i,
  output logic [31:0] result_o
);
  logic [31:0] mag;
  // Magnitude first, so a negative root operand still yields a value
  assign mag = x_i[31] ? (~x_i + 32'h0000_0001) : x_i;
  // Sum for two operands; half magnitude gives a 0.5 fraction to round
  assign result_o = (cmd_i == RPNSC_DYADIC) ? (y_i + x_i) : (mag >> 1);
endmodule : rpnsc_alu_model

/* File: rpnsc_pkg.sv */
// Purpose: Shared constants and types for the operand stack block
// Assumes: Values are signed Q16.16 fixed point
// Notes: Dyadic, root, exponential and natural log results arrive from the datapath on result_i
package rpnsc_pkg;
  localparam int DW = 32;
  localparam int FRAC = 16;
  localparam logic [31:0] ONE_Q = 32'h0001_0000;
  localparam logic [31:0] HALF_Q = 32'h0000_8000;
  localparam logic [31:0] TEN_Q = 32'h0000_000A;
  localparam logic [15:0] FRAC_MASK = 16'hFFFF;
  localparam int CONST_DEPTH = 100;
  localparam logic [6:0] ADDR_MAX_STD = 7'h31;
  localparam logic [6:0] ADDR_MAX_EXT = 7'h63;
  localparam logic [31:0] STACK_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    RPNSC_NOP, RPNSC_DIGIT, RPNSC_ENTER, RPNSC_ROLL, RPNSC_EXCH,
    RPNSC_CLEAR_STACK, RPNSC_DYADIC, RPNSC_ROOT, RPNSC_EXPONENTIAL,
    RPNSC_NATURAL_LOG, RPNSC_MAGNITUDE, RPNSC_SIGN, RPNSC_STORE_CONSTANT,
    RPNSC_RECALL_CONSTANT, RPNSC_CHANGE_SIGN
  } rpnsc_cmd_t;
endpackage : rpnsc_pkg

/* File: rpnsc_stack.sv */
// Purpose: Five-level operand stack (W,T,Z,Y,X) plus constant registers
// Assumes: One command per valid cycle; datapath result valid with it
// Notes: All outputs registered; warnings and errors are 1-cycle pulses
`timescale 1ns/1ps
module rpnsc_stack
  import rpnsc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire rpnsc_cmd_t cmd_i,
  input wire logic [3:0] digit_i,
  input wire logic [31:0] result_i,
  input wire logic ext_range_i,
  output logic [31:0] x_o,
  output logic [31:0] y_o,
  output logic [31:0] z_o,
  output logic [31:0] t_o,
  output logic [31:0] w_o,
  output logic entry_o,
  output logic negative_root_warning_o,
  output logic bad_log_warning_o,
  output logic addr_error_o
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Round Q16.16 to nearest integer, saturating negative to an invalid code
  function automatic logic [7:0] rpnsc_round_addr(input logic [31:0] v);
    logic [31:0] r;
    r = v + HALF_Q;
    if (r[31] || (r[31:FRAC] > 16'h00FF)) begin
      rpnsc_round_addr = 8'hFF;
    end else begin
      rpnsc_round_addr = r[FRAC+7:FRAC];
    end
  endfunction : rpnsc_round_addr

  // Address limit depends on the extended-range strap
  function automatic logic rpnsc_addr_ok(input logic [7:0] a, input logic ext);
    rpnsc_addr_ok = ext ? (a <= {1'b0, ADDR_MAX_EXT}) : (a <= {1'b0, ADDR_MAX_STD});
  endfunction : rpnsc_addr_ok

  // Two's complement negate, shared by magnitude, sign and change sign
  function automatic logic [31:0] rpnsc_negate(input logic [31:0] v);
    rpnsc_negate = 32'h0000_0000 - v;
  endfunction : rpnsc_negate

  ////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] x_r, y_r, z_r, t_r, w_r;
  logic entry_r;
  logic [31:0] const_mem [CONST_DEPTH];
  logic [7:0] addr_rnd;
  logic addr_int;
  logic store_ok, recall_ok;
  logic [31:0] x_mag;
  logic [31:0] digit_q;

  // Decoded address and its validity, shared by store and recall
  always_comb begin
    addr_rnd = rpnsc_round_addr(x_r);
    addr_int = (x_r[FRAC-1:0] == 16'h0000); // Store needs an exact integer
    store_ok = addr_int && rpnsc_addr_ok(addr_rnd, ext_range_i);
    recall_ok = rpnsc_addr_ok(addr_rnd, ext_range_i);
    x_mag = x_r[31] ? rpnsc_negate(x_r) : x_r;
    digit_q = {12'h000, digit_i, 16'h0000};
  end

  ////////////////////////////////////////////////////////////////////
  // Stack registers: one case per command except NOP, which takes the default, with root, exponential and natural log sharing one

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      x_r <= STACK_RST;
      y_r <= STACK_RST;
      z_r <= STACK_RST;
      t_r <= STACK_RST;
      w_r <= STACK_RST;
    end else if (cmd_valid_i) begin
      case (cmd_i)
        RPNSC_DIGIT: begin
          if (!entry_r) begin
            // Push first so the old X (even a function result) lands in Y
            x_r <= digit_q;
            y_r <= x_r;
            z_r <= y_r;
            t_r <= z_r;
            w_r <= t_r;
          end else begin
            x_r <= 32'(x_r * TEN_Q) + digit_q; // Integer digits only
          end
        end
        RPNSC_ENTER: begin
          if (!entry_r) begin
            y_r <= x_r;
            z_r <= y_r;
            t_r <= z_r;
            w_r <= t_r;
          end
        end
        RPNSC_ROLL: begin
          // Values move, slots stay: five rolls is the identity
          w_r <= x_r;
          x_r <= y_r;
          y_r <= z_r;
          z_r <= t_r;
          t_r <= w_r;
        end
        RPNSC_EXCH: begin
          x_r <= y_r;
          y_r <= x_r;
        end
        RPNSC_CLEAR_STACK: begin
          x_r <= STACK_RST;
          y_r <= STACK_RST;
          z_r <= STACK_RST;
          t_r <= STACK_RST;
          w_r <= STACK_RST;
        end
        RPNSC_DYADIC: begin
          // Drop: W duplicates into T since nothing refills it
          x_r <= result_i;
          y_r <= z_r;
          z_r <= t_r;
          t_r <= w_r;
        end
        RPNSC_ROOT, RPNSC_EXPONENTIAL, RPNSC_NATURAL_LOG: begin
          x_r <= result_i;
        end
        RPNSC_MAGNITUDE: begin
          x_r <= x_mag;
        end
        RPNSC_SIGN: begin
          if (x_r == 32'h0000_0000) begin
            x_r <= 32'h0000_0000;
          end else if (x_r[31]) begin
            x_r <= rpnsc_negate(ONE_Q);
          end else begin
            x_r <= ONE_Q;
          end
        end
        RPNSC_CHANGE_SIGN: begin
          x_r <= rpnsc_negate(x_r);
        end
        RPNSC_STORE_CONSTANT: begin
          if (store_ok) begin
            x_r <= y_r;
            y_r <= z_r;
            z_r <= t_r;
            t_r <= w_r;
          end
        end
        RPNSC_RECALL_CONSTANT: begin
          // Pop address then push constant: only X changes in net
          if (recall_ok) begin
            x_r <= const_mem[addr_rnd[6:0]];
          end
        end
        default: begin
          x_r <= x_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Numeric entry state

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      entry_r <= 1'b0;
    end else if (cmd_valid_i) begin
      case (cmd_i)
        RPNSC_DIGIT: entry_r <= 1'b1;
        RPNSC_CHANGE_SIGN: entry_r <= entry_r;
        RPNSC_NOP: entry_r <= entry_r;
        default: entry_r <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Constant registers: written only by a valid store

  // No reset on the array; storing zero is how a constant is cleared
  always_ff @(posedge ref_clk_i) begin
    if (cmd_valid_i && (cmd_i == RPNSC_STORE_CONSTANT) && store_ok) begin
      const_mem[addr_rnd[6:0]] <= y_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Warning and error pulses

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      negative_root_warning_o <= 1'b0;
      bad_log_warning_o <= 1'b0;
      addr_error_o <= 1'b0;
    end else begin
      negative_root_warning_o <= cmd_valid_i && (cmd_i == RPNSC_ROOT) && x_r[31];
      bad_log_warning_o <= cmd_valid_i && (cmd_i == RPNSC_NATURAL_LOG)
                           && (x_r[31] || (x_r == 32'h0000_0000));
      addr_error_o <= cmd_valid_i
                      && (((cmd_i == RPNSC_STORE_CONSTANT) && !store_ok)
                      || ((cmd_i == RPNSC_RECALL_CONSTANT) && !recall_ok));
    end
  end

  // Outputs mirror the registers directly
  assign x_o = x_r;
  assign y_o = y_r;
  assign z_o = z_r;
  assign t_o = t_r;
  assign w_o = w_r;
  assign entry_o = entry_r;

  ////////////////////////////////////////////////////////////////////
  // Checks

  roll_rotate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_ROLL |=> w_r == $past(x_r) && x_r == $past(y_r)
      && y_r == $past(z_r) && z_r == $past(t_r)
      && t_r == $past(w_r))
    else $error("Roll did not rotate");

  exch_swap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_EXCH |=> x_r == $past(y_r) && y_r == $past(x_r)
      && $stable(z_r) && $stable(t_r) && $stable(w_r))
    else $error("Exchange wrong");

  clear_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_CLEAR_STACK |=> (x_r | y_r | z_r | t_r | w_r) == 0)
    else $error("Stack not cleared");

  digit_push_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_DIGIT && !entry_r |=> y_r == $past(x_r) && entry_r)
    else $error("Digit did not push");

  enter_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_ENTER && entry_r |=> !entry_r && $stable(y_r))
    else $error("Enter in entry pushed");

  enter_dup_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_ENTER && !entry_r |=> y_r == x_r && $stable(x_r))
    else $error("Enter did not duplicate X");

  dyadic_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_DYADIC |=> x_r == $past(result_i)
      && y_r == $past(z_r) && z_r == $past(t_r))
    else $error("Dyadic drop wrong");

  mono_only_x_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i inside {RPNSC_ROOT, RPNSC_EXPONENTIAL, RPNSC_NATURAL_LOG,
      RPNSC_MAGNITUDE, RPNSC_SIGN} |=> $stable(y_r) && $stable(z_r) && $stable(t_r)
      && $stable(w_r))
    else $error("Single-operand touched stack");

  sign_value_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_SIGN && !x_r[31] && x_r != 0 |=> x_r == ONE_Q)
    else $error("Sign of positive not one");

  root_warn_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    negative_root_warning_o |-> $past(cmd_valid_i) && $past(x_r[31])
      && $past(cmd_i) == RPNSC_ROOT)
    else $error("Spurious root warning");

  bad_addr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_STORE_CONSTANT && !store_ok
      |=> addr_error_o && $stable(x_r) && $stable(y_r))
    else $error("Bad address changed stack");

  recall_get_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_RECALL_CONSTANT && recall_ok
      |=> x_r == const_mem[$past(addr_rnd[6:0])] && $stable(y_r))
    else $error("Recall wrong");

  func_new_entry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i inside {RPNSC_DYADIC, RPNSC_ROOT, RPNSC_EXPONENTIAL,
      RPNSC_NATURAL_LOG, RPNSC_MAGNITUDE, RPNSC_SIGN} |=> !entry_r)
    else $error("Function left entry open");

  push_shift_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_ENTER && !entry_r |=> z_r == $past(y_r)
      && t_r == $past(z_r) && w_r == $past(t_r))
    else $error("Push did not shift up");

  sign_minus_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_SIGN && x_r[31] |=> (x_r + ONE_Q) == 32'h0000_0000)
    else $error("Sign of negative not minus one");

  mag_value_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_MAGNITUDE |=> ($past(x_r[31])
      ? ((x_r + $past(x_r)) == 32'h0000_0000) : (x_r == $past(x_r))))
    else $error("Magnitude wrong");

  root_raise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_ROOT && x_r[31] |=> negative_root_warning_o)
    else $error("Root warning missing");

  log_warn_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_NATURAL_LOG && (x_r[31] || x_r == 32'h0000_0000)
      |=> bad_log_warning_o)
    else $error("Log warning missing");

  exp_result_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_EXPONENTIAL |=> x_r == $past(result_i))
    else $error("Exponential result not in X");

  store_pop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_STORE_CONSTANT && store_ok |=> x_r == $past(y_r)
      && y_r == $past(z_r) && const_mem[$past(addr_rnd[6:0])] == $past(y_r))
    else $error("Store did not copy and pop");

  recall_bad_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_RECALL_CONSTANT && !recall_ok
      |=> addr_error_o && $stable(x_r) && $stable(y_r))
    else $error("Bad recall changed stack");

  recall_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == RPNSC_RECALL_CONSTANT && recall_ok
      |=> const_mem[$past(addr_rnd[6:0])] == $past(const_mem[addr_rnd[6:0]]))
    else $error("Recall altered constant");

endmodule : rpnsc_stack

/* File: tb_top.sv */
// Purpose: Self-checking bench for the operand stack and constants
// Assumes: One command per two cycles, results one edge later
// Notes: Expected values are built here in Q16.16
`timescale 1ns/1ps
module tb_top
  import rpnsc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  rpnsc_cmd_t cmd_i = RPNSC_NOP;
  logic [3:0] digit_i = 4'h0;
  logic [31:0] result_i;
  logic ext_range_i = 1'b0;
  logic [31:0] x_o, y_o, z_o, t_o, w_o;
  logic entry_o, nrw_o, blw_o, err_o;
  int mismatches = 0;
  int samples_checked = 0;
  // 20 MHz processor clock
  always #25 ref_clk_i = ~ref_clk_i;
  rpnsc_stack dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .digit_i(digit_i), .result_i(result_i), .ext_range_i(ext_range_i),
    .x_o(x_o), .y_o(y_o), .z_o(z_o), .t_o(t_o), .w_o(w_o), .entry_o(entry_o),
    .negative_root_warning_o(nrw_o), .bad_log_warning_o(blw_o), .addr_error_o(err_o));
  rpnsc_alu_model alu_u (.cmd_i(cmd_i), .x_i(x_o), .y_i(y_o), .result_o(result_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] q(input int n);
    return 32'(n) << FRAC;
  endfunction : q
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request rises on one edge, is taken on the next; outputs read 1 ns later
  task automatic cmd(input rpnsc_cmd_t c, input int d = 0);
    @(posedge ref_clk_i);
    cmd_i <= c;
    digit_i <= 4'(d);
    cmd_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    cmd_i <= RPNSC_NOP;
    #1;
  endtask : cmd
  task automatic stk(input int w, t, z, y, x);
    chk("w", w_o, q(w));
    chk("t", t_o, q(t));
    chk("z", z_o, q(z));
    chk("y", y_o, q(y));
    chk("x", x_o, q(x));
  endtask : stk
  // Leaves W..X holding 1..5 with entry ended
  task automatic load5();
    cmd(RPNSC_CLEAR_STACK);
    for (int i = 1; i <= 5; i++) begin
      cmd(RPNSC_DIGIT, i);
      cmd(RPNSC_ENTER);
    end
  endtask : load5
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_entry();
    cmd(RPNSC_CLEAR_STACK);
    cmd(RPNSC_DIGIT, 4);
    cmd(RPNSC_DIGIT, 5);
    chk("entry", {31'h0, entry_o}, 32'h1);
    cmd(RPNSC_ENTER);
    stk(0, 0, 0, 0, 45);
    cmd(RPNSC_DIGIT, 8);
    stk(0, 0, 0, 45, 8);
    cmd(RPNSC_ENTER);
    cmd(RPNSC_ENTER);
    stk(0, 0, 45, 8, 8);
    cmd(RPNSC_DYADIC);
    stk(0, 0, 0, 45, 16);
    cmd(RPNSC_DIGIT, 2);
    stk(0, 0, 45, 16, 2);
  endtask : t_entry
  task automatic t_shuffle();
    load5();
    cmd(RPNSC_ROLL);
    stk(5, 1, 2, 3, 4);
    repeat (4) cmd(RPNSC_ROLL);
    stk(1, 2, 3, 4, 5);
    cmd(RPNSC_EXCH);
    stk(1, 2, 3, 5, 4);
    cmd(RPNSC_EXCH);
    cmd(RPNSC_ENTER);
    stk(2, 3, 4, 5, 5);
    cmd(RPNSC_CLEAR_STACK);
    stk(0, 0, 0, 0, 0);
  endtask : t_shuffle
  task automatic t_mono();
    load5();
    cmd(RPNSC_SIGN);
    stk(1, 2, 3, 4, 1);
    cmd(RPNSC_CHANGE_SIGN);
    cmd(RPNSC_SIGN);
    chk("x", x_o, q(-1));
    cmd(RPNSC_MAGNITUDE);
    stk(1, 2, 3, 4, 1);
    cmd(RPNSC_CLEAR_STACK);
    cmd(RPNSC_SIGN);
    chk("x", x_o, q(0));
    cmd(RPNSC_NATURAL_LOG);
    chk("log warn", {31'h0, blw_o}, 32'h1);
    cmd(RPNSC_DIGIT, 8);
    cmd(RPNSC_CHANGE_SIGN);
    cmd(RPNSC_ROOT);
    chk("root warn", {31'h0, nrw_o}, 32'h1);
    chk("x", x_o, q(4));
    cmd(RPNSC_EXPONENTIAL);
    chk("root warn", {31'h0, nrw_o}, 32'h0);
    stk(0, 0, 0, 0, 2);
  endtask : t_mono
  task automatic t_const();
    @(posedge ref_clk_i);
    ext_range_i <= 1'b0;
    cmd(RPNSC_CLEAR_STACK);
    cmd(RPNSC_DIGIT, 7);
    cmd(RPNSC_ENTER);
    cmd(RPNSC_DIGIT, 5);
    cmd(RPNSC_STORE_CONSTANT);
    chk("error", {31'h0, err_o}, 32'h0);
    stk(0, 0, 0, 0, 7);
    cmd(RPNSC_DIGIT, 5);
    cmd(RPNSC_RECALL_CONSTANT);
    stk(0, 0, 0, 7, 7);
    cmd(RPNSC_DIGIT, 5);
    cmd(RPNSC_RECALL_CONSTANT);
    chk("x", x_o, q(7));
    cmd(RPNSC_DIGIT, 9);
    cmd(RPNSC_ROOT);
    cmd(RPNSC_STORE_CONSTANT);
    chk("error", {31'h0, err_o}, 32'h1);
    cmd(RPNSC_RECALL_CONSTANT);
    chk("x", x_o, q(7));
    cmd(RPNSC_DIGIT, 5);
    cmd(RPNSC_DIGIT, 0);
    cmd(RPNSC_STORE_CONSTANT);
    chk("error", {31'h0, err_o}, 32'h1);
    chk("x", x_o, q(50));
    cmd(RPNSC_RECALL_CONSTANT);
    chk("error", {31'h0, err_o}, 32'h1);
    stk(7, 7, 7, 7, 50);
    @(posedge ref_clk_i);
    ext_range_i <= 1'b1;
    cmd(RPNSC_STORE_CONSTANT);
    chk("error", {31'h0, err_o}, 32'h0);
    cmd(RPNSC_DIGIT, 5);
    cmd(RPNSC_DIGIT, 0);
    cmd(RPNSC_RECALL_CONSTANT);
    chk("x", x_o, q(7));
  endtask : t_const
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    stk(0, 0, 0, 0, 0);
    t_entry();
    t_shuffle();
    t_mono();
    t_const();
    summarize();
  end
endmodule : tb_top
